// ===== logic/cbcs_top.sv
// Purpose: Channel B pin-level control, loss flag, reference and clock-out selection
// Assumes: All pins synchronous to ref_clk; analog levels arrive as mVpp codes
// Notes: Avalon-MM slave, one wait state on every access
`timescale 1ns/1ps
`include "cbcs_map.svh"
module cbcs_top #(
  parameter int LANES = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Avalon-MM slave
  input  wire logic [`CBCS_ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic [1:0]             avs_response,
  // Datapath lanes
  input  wire logic [LANES-1:0]  slow_parallel_in_second,
  output logic [LANES-1:0]       lanes_to_serializer,
  input  wire logic [LANES-1:0]  lanes_from_deserializer,
  output logic [LANES-1:0]       slow_parallel_out_second,
  input  wire logic              serializer_bit,
  output logic                   fast_serial_tx_second,
  input  wire logic [7:0]        fast_serial_rx_second_mvpp,
  // Pins
  input  wire logic              power_down_pin_second_n,
  input  wire logic              power_down_pin_first_n,
  input  wire logic              pd_reg_first,
  input  wire logic              ref_select_pin_second,
  output logic                   ref_use_clock_one,
  output logic                   signal_loss_flag_second_o,
  output logic                   signal_loss_flag_second_oe,
  // Clock sources as one-cycle ticks
  input  wire logic              byte_tick_second,
  input  wire logic              byte_tick_first,
  input  wire logic              vco_tick,
  output logic                   clock_output_second_o,
  output logic                   clock_output_second_oe,
  output logic                   byte_clock_to_first,
  output logic                   datapath_reset,
  output logic                   irq
);
  typedef struct packed {
    logic [31:0]                 ctrl;
    logic [31:0]                 clk;
    logic [`CBCS_IRQ_W-1:0]      ists;
    logic [`CBCS_IRQ_W-1:0]      imask;
    logic                        los;
    logic                        pd_seen;
    logic                        ack;
    logic [31:0]                 rdata;
    logic [1:0]                  resp;
    logic [LANES-1:0]            tx_lanes;
    logic [LANES-1:0]            rx_lanes;
    logic                        ser;
    logic                        ref_one;
    logic                        los_o;
    logic                        los_oe;
    logic                        ck_o;
    logic                        ck_oe;
    logic                        to_first;
    logic                        dprst;
    logic                        irq;
  } cbcs_st_s;

  cbcs_st_s st_r;
  cbcs_st_s st_nxt;

  cbcs_pkg::cbcs_ratio_e ratio;
  cbcs_pkg::cbcs_src_e   src;
  cbcs_pkg::cbcs_obs_e   obs;
  cbcs_pkg::cbcs_div_e   div_sel;
  logic                  pd_chan;
  logic                  pd_both;
  logic                  div_tick;
  logic                  div_clk;
  logic [LANES-1:0]      lane_mask;
  logic                  obs_bit;
  logic                  req;
  logic [31:0]           wmask;
  logic [`CBCS_IRQ_W-1:0] ev;

  assign ratio   = cbcs_pkg::cbcs_ratio_e'(st_r.ctrl[`CBCS_CTRL_RATIO_LO +: 2]);
  assign obs     = cbcs_pkg::cbcs_obs_e'(st_r.ctrl[`CBCS_CTRL_OBS_LO +: 2]);
  assign src     = cbcs_pkg::cbcs_src_e'(st_r.clk[`CBCS_CLK_SRC_LO +: 2]);
  assign div_sel = cbcs_pkg::cbcs_div_e'(st_r.clk[`CBCS_CLK_DIV_LO +: 4]);
  assign pd_chan = !power_down_pin_second_n || st_r.ctrl[`CBCS_CTRL_PD_BIT];
  assign pd_both = (!power_down_pin_second_n && !power_down_pin_first_n)
                || (st_r.ctrl[`CBCS_CTRL_PD_BIT] && pd_reg_first);
  assign req     = (avs_read || avs_write) && !st_r.ack;

  // Source for clock out; first channel clock may be steered here
  always_comb begin
    case (src)
      cbcs_pkg::CBCS_SRC_BYTE:  div_tick = byte_tick_second;
      cbcs_pkg::CBCS_SRC_VCO2:  div_tick = vco_tick;
      cbcs_pkg::CBCS_SRC_FIRST: div_tick = byte_tick_first;
      default:                  div_tick = 1'b0;
    endcase
  end

  cbcs_clkdiv u_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (div_tick),
    .ratio   (div_sel),
    .clk_div (div_clk)
  );

  // Lanes in use per ratio
  always_comb begin
    case (ratio)
      cbcs_pkg::CBCS_R11: lane_mask = LANES'(4'h1);
      cbcs_pkg::CBCS_R21: lane_mask = LANES'(4'h3);
      default:            lane_mask = {LANES{1'b1}};
    endcase
  end

  // Observation mux for the loss pin
  always_comb begin
    case (obs)
      cbcs_pkg::CBCS_OBS_LOS: obs_bit = st_r.los;
      cbcs_pkg::CBCS_OBS_REF: obs_bit = st_r.ref_one;
      cbcs_pkg::CBCS_OBS_PD:  obs_bit = pd_chan;
      cbcs_pkg::CBCS_OBS_CLK: obs_bit = div_clk;
      default:                obs_bit = st_r.los;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{avs_byteenable[i]}};
    end
  end

  always_comb begin
    st_nxt = st_r;
    ev     = '0;
    // Loss detector with hysteresis
    if (!st_r.ctrl[`CBCS_CTRL_LOSEN]) begin
      st_nxt.los = 1'b0;
    end else if (!st_r.los && fast_serial_rx_second_mvpp < `CBCS_LOS_ASSERT_MV) begin
      st_nxt.los = 1'b1;
      ev[`CBCS_IRQ_LOS_SET] = 1'b1;
    end else if (st_r.los && fast_serial_rx_second_mvpp > `CBCS_LOS_DEASSERT_MV) begin
      st_nxt.los = 1'b0;
      ev[`CBCS_IRQ_LOS_CLR] = 1'b1;
    end
    st_nxt.pd_seen = pd_chan;
    ev[`CBCS_IRQ_PD_CHG] = pd_chan != st_r.pd_seen;

    // Bus slave, one wait cycle then acknowledge
    st_nxt.ack   = req;
    st_nxt.resp  = 2'h0;
    st_nxt.dprst = 1'b0;
    st_nxt.ists  = st_r.ists;
    if (req && avs_write) begin
      case (avs_address)
        `CBCS_OFF_CTRL: begin
          st_nxt.ctrl  = (st_r.ctrl & ~wmask) | (avs_writedata & wmask);
          st_nxt.dprst = avs_writedata[`CBCS_CTRL_DPRST] && avs_byteenable[0];
          st_nxt.ctrl[`CBCS_CTRL_DPRST] = 1'b0;
        end
        `CBCS_OFF_CLK:      st_nxt.clk = (st_r.clk & ~wmask) | (avs_writedata & wmask);
        `CBCS_OFF_IRQ_STAT: st_nxt.ists = st_r.ists
                                        & ~(avs_writedata[`CBCS_IRQ_W-1:0]
                                            & wmask[`CBCS_IRQ_W-1:0]);
        `CBCS_OFF_IRQ_MASK: st_nxt.imask = (st_r.imask & ~wmask[`CBCS_IRQ_W-1:0])
                                         | (avs_writedata[`CBCS_IRQ_W-1:0]
                                            & wmask[`CBCS_IRQ_W-1:0]);
        `CBCS_OFF_STATUS:   st_nxt.resp = 2'h0;
        `CBCS_OFF_LEVEL:    st_nxt.resp = 2'h0;
        default:            st_nxt.resp = 2'h2;
      endcase
    end
    // Set beats clear on the same cycle
    st_nxt.ists = st_nxt.ists | ev;
    if (req && avs_read) begin
      case (avs_address)
        `CBCS_OFF_CTRL:      st_nxt.rdata = st_r.ctrl;
        `CBCS_OFF_CLK:       st_nxt.rdata = st_r.clk;
        `CBCS_OFF_STATUS:    st_nxt.rdata = {28'h0000000, pd_both, pd_chan, st_r.ref_one,
                                             st_r.los};
        `CBCS_OFF_IRQ_STAT:  st_nxt.rdata = {29'h00000000, st_r.ists};
        `CBCS_OFF_IRQ_MASK:  st_nxt.rdata = {29'h00000000, st_r.imask};
        `CBCS_OFF_LEVEL:     st_nxt.rdata = {24'h000000, fast_serial_rx_second_mvpp};
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.resp  = 2'h2;
        end
      endcase
    end
    st_nxt.irq = |(st_nxt.ists & st_nxt.imask);

    // Reference select: pin ORed with software bit, pin tied low for software use
    st_nxt.ref_one = ref_select_pin_second || st_r.ctrl[`CBCS_CTRL_REF_BIT];

    // Lane gating and serial output, zeroed while powered down
    st_nxt.tx_lanes = pd_chan ? '0 : (slow_parallel_in_second & lane_mask);
    st_nxt.rx_lanes = pd_chan ? '0 : (lanes_from_deserializer & lane_mask);
    st_nxt.ser      = pd_chan ? 1'b0 : serializer_bit;

    // Loss pin floats in power down
    st_nxt.los_oe = !pd_chan;
    st_nxt.los_o  = pd_chan ? 1'b0 : obs_bit;

    // Clock out and steering to the first channel pins
    st_nxt.ck_oe    = !pd_both && st_r.clk[`CBCS_CLK_EN_BIT];
    st_nxt.ck_o     = st_nxt.ck_oe ? div_clk : 1'b0;
    st_nxt.to_first = st_r.clk[`CBCS_CLK_FIRST_BIT] && !pd_chan && byte_tick_second;
  end

  // Reset puts zeros on every driven pin except avs_waitrequest, which is high, and loss pin low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r        <= '0;
      st_r.ctrl   <= `CBCS_CTRL_RESET;
      st_r.clk    <= `CBCS_CLK_RESET;
      st_r.los_oe <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata               = st_r.rdata;
  assign avs_waitrequest            = !st_r.ack;
  assign avs_response               = st_r.resp;
  assign lanes_to_serializer        = st_r.tx_lanes;
  assign slow_parallel_out_second   = st_r.rx_lanes;
  assign fast_serial_tx_second      = st_r.ser;
  assign ref_use_clock_one          = st_r.ref_one;
  assign signal_loss_flag_second_o  = st_r.los_o;
  assign signal_loss_flag_second_oe = st_r.los_oe;
  assign clock_output_second_o      = st_r.ck_o;
  assign clock_output_second_oe     = st_r.ck_oe;
  assign byte_clock_to_first        = st_r.to_first;
  assign datapath_reset             = st_r.dprst;
  assign irq                        = st_r.irq;

  sequence s_low_swing;
    st_r.ctrl[`CBCS_CTRL_LOSEN] && !st_r.los
      && fast_serial_rx_second_mvpp < `CBCS_LOS_ASSERT_MV;
  endsequence
  // Two clock edges in reset, so a reset edge missed at time zero cannot trip these
  sequence s_in_reset;
    !resetn ##1 !resetn;
  endsequence
  sequence s_req_taken;
    req;
  endsequence
  sequence s_ack_given;
    !avs_waitrequest;
  endsequence

  chk_los_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_low_swing |=> st_r.los)
    else $error("loss flag did not set below low threshold");

  chk_los_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_r.los && st_r.ctrl[`CBCS_CTRL_LOSEN]
      && fast_serial_rx_second_mvpp <= `CBCS_LOS_DEASSERT_MV |=> st_r.los)
    else $error("loss flag cleared inside hysteresis band");

  chk_los_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_r.los && st_r.ctrl[`CBCS_CTRL_LOSEN]
      && fast_serial_rx_second_mvpp > `CBCS_LOS_DEASSERT_MV |=> !st_r.los)
    else $error("loss flag stuck above high threshold");

  chk_los_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
    obs == cbcs_pkg::CBCS_OBS_LOS && !pd_chan
      |=> signal_loss_flag_second_o == $past(st_r.los))
    else $error("loss pin does not follow the loss flag");

  chk_obs_ref: assert property (@(posedge ref_clk) disable iff (!resetn)
    obs == cbcs_pkg::CBCS_OBS_REF && !pd_chan
      |=> signal_loss_flag_second_o == $past(st_r.ref_one))
    else $error("loss pin does not show the reference choice");

  chk_lane_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    ratio == cbcs_pkg::CBCS_R11 |=> lanes_to_serializer[LANES-1:1] == '0)
    else $error("unused transmit lane passed at 1:1");

  chk_lane_two: assert property (@(posedge ref_clk) disable iff (!resetn)
    ratio == cbcs_pkg::CBCS_R21 |=> slow_parallel_out_second[LANES-1:2] == '0)
    else $error("unused receive lane driven at 2:1");

  chk_lane_four: assert property (@(posedge ref_clk) disable iff (!resetn)
    ratio == cbcs_pkg::CBCS_R41 && !pd_chan
      |=> lanes_to_serializer == $past(slow_parallel_in_second))
    else $error("transmit lane dropped at 4:1");

  chk_pd_blank: assert property (@(posedge ref_clk) disable iff (!resetn)
    pd_chan |=> !fast_serial_tx_second && slow_parallel_out_second == '0)
    else $error("data outputs active in power down");

  chk_reset_quiet: assert property (@(posedge ref_clk)
    s_in_reset |-> !fast_serial_tx_second && !clock_output_second_o
      && slow_parallel_out_second == '0)
    else $error("driven output not zero in reset");

  chk_reset_los: assert property (@(posedge ref_clk)
    s_in_reset |-> signal_loss_flag_second_oe && !signal_loss_flag_second_o)
    else $error("loss pin not driven low in reset");

  chk_ref_default: assert property (@(posedge ref_clk)
    s_in_reset |-> !ref_use_clock_one)
    else $error("reference clock one chosen in reset");

  chk_los_float: assert property (@(posedge ref_clk) disable iff (!resetn)
    pd_chan |=> !signal_loss_flag_second_oe)
    else $error("loss pin driven in power down");

  chk_ck_float: assert property (@(posedge ref_clk) disable iff (!resetn)
    pd_both |=> !clock_output_second_oe)
    else $error("clock out driven with both channels down");

  chk_ck_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st_r.clk[`CBCS_CLK_EN_BIT] |=> !clock_output_second_oe && !clock_output_second_o)
    else $error("clock out active while disabled");

  chk_ck_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
    !pd_both && st_r.clk[`CBCS_CLK_EN_BIT] |=> clock_output_second_o == $past(div_clk))
    else $error("clock out does not follow the divider");

  chk_steer_pass: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_r.clk[`CBCS_CLK_FIRST_BIT] && !pd_chan && byte_tick_second |=> byte_clock_to_first)
    else $error("byte clock not steered to the first pins");

  chk_ref_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
    ref_select_pin_second |=> ref_use_clock_one)
    else $error("reference pin high did not pick clock one");

  chk_ref_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ref_select_pin_second && !st_r.ctrl[`CBCS_CTRL_REF_BIT] |=> !ref_use_clock_one)
    else $error("reference clock one chosen with pin and bit low");

  chk_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    ##1 irq == $past(|(st_nxt.ists & st_nxt.imask)))
    else $error("interrupt level mismatch");

  chk_irq_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    ev != '0 |=> (st_r.ists & $past(ev)) == $past(ev))
    else $error("status event lost to a clear");

  chk_bus_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
    req ##1 (avs_read || avs_write) |-> !avs_waitrequest)
    else $error("bus answer late");

  chk_wait_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_req_taken |=> s_ack_given)
    else $error("bus answer not one cycle after request");

  chk_unmapped_read: assert property (@(posedge ref_clk) disable iff (!resetn)
    req && avs_read && avs_address > `CBCS_OFF_LEVEL
      |=> avs_response == 2'h2 && avs_readdata == 32'h00000000)
    else $error("unmapped read not refused");
endmodule : cbcs_top

// ===== logic/cbcs_map.svh
// Purpose: Offsets, fields, reset values and counts for the channel B clock and status block
// Assumes: Avalon-MM word addressing on a 32-bit bus; byte address = 4 * word index
// Notes: Offsets, fields, reset values and thresholds live here; divider limits and lane masks sit in the modules
// Contract
// - Transmit inputs: lane 0 only at 1:1, lanes 1 and 0 at 2:1.
// - Receive outputs: drive lane 0 only at 1:1, lanes 1 and 0 at 2:1.
// - During reset serial out, parallel outs and clock out hold zero.
// - Loss flag reads 0 with signal present, 1 when signal lost.
// - When enabled, loss sets below 75 mVpp, clears only above 150 mVpp.
// - Management can switch the loss pin to show other internal functions.
// - Loss pin low in reset, floating in pin or register power down.
// - Reference select pin low picks clock zero, high picks clock one; code ORs in control bit 1, so that bit high picks clock one with the pin low.
// - After reset the channel uses reference clock zero.
// - Clock out defaults enabled, carrying recovered clock, line rate over 20.
// - Clock out may carry oscillator clock divided by two instead.
// - Clock out offers divide ratios 1, 2, 4, 5, 8, 10, 16, 20, 25.
// - Clock out floats when both channels are powered down by pin or register; code keeps it driven when one is down by pin and the other by register.
// - This channel's recovered clock may be steered to the first clock pins.
// - Channel powers down while its power-down pin is low.
// - The first channel's recovered clock may be steered onto this channel's pins.
`ifndef CBCS_MAP_SVH
`define CBCS_MAP_SVH

`define CBCS_ADDR_W        4
`define CBCS_OFF_CTRL      4'h0
`define CBCS_OFF_CLK       4'h1
`define CBCS_OFF_STATUS    4'h2
`define CBCS_OFF_IRQ_STAT  4'h3
`define CBCS_OFF_IRQ_MASK  4'h4
`define CBCS_OFF_LEVEL     4'h5

// Control word fields
`define CBCS_CTRL_PD_BIT   15
`define CBCS_CTRL_REF_BIT  1
`define CBCS_CTRL_LOSEN    2
`define CBCS_CTRL_DPRST    3
`define CBCS_CTRL_OBS_LO   4
`define CBCS_CTRL_RATIO_LO 8
`define CBCS_CTRL_RESET    32'h0000_0004

// Clock word fields
`define CBCS_CLK_EN_BIT    0
`define CBCS_CLK_SRC_LO    1
`define CBCS_CLK_DIV_LO    4
`define CBCS_CLK_FIRST_BIT 8
`define CBCS_CLK_RESET     32'h0000_0001

// Status and interrupt bits
`define CBCS_IRQ_LOS_SET   0
`define CBCS_IRQ_LOS_CLR   1
`define CBCS_IRQ_PD_CHG    2
`define CBCS_IRQ_W         3

// Swing thresholds in mVpp
`define CBCS_LOS_ASSERT_MV   8'h4B
`define CBCS_LOS_DEASSERT_MV 8'h96

// Byte clock is line rate over this figure
`define CBCS_BYTE_DIV        20

`endif

// ===== logic/cbcs_pkg.sv
// Purpose: Types for the channel B clock and status block
// Assumes: Constants come from cbcs_map.svh
// Notes: Encodings of modes and sources
package cbcs_pkg;
  typedef enum logic [1:0] {CBCS_R11, CBCS_R21, CBCS_R41, CBCS_RRSV} cbcs_ratio_e;
  typedef enum logic [1:0] {CBCS_SRC_BYTE, CBCS_SRC_VCO2, CBCS_SRC_FIRST, CBCS_SRC_OFF} cbcs_src_e;
  typedef enum logic [1:0] {CBCS_OBS_LOS, CBCS_OBS_REF, CBCS_OBS_PD, CBCS_OBS_CLK} cbcs_obs_e;
  typedef enum logic [3:0] {CBCS_D1, CBCS_D2, CBCS_D4, CBCS_D5, CBCS_D8, CBCS_D10, CBCS_D16,
                            CBCS_D20, CBCS_D25} cbcs_div_e;
endpackage : cbcs_pkg

// ===== logic/cbcs_clkdiv.sv
// Purpose: Selectable clock-out divider as a toggling enable chain
// Assumes: Source ticks arrive as one-cycle pulses on ref_clk
// Notes: Output toggles every ratio source ticks; odd ratios give even duty as well
`timescale 1ns/1ps
`include "cbcs_map.svh"
module cbcs_clkdiv (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              tick,
  input  wire cbcs_pkg::cbcs_div_e ratio,
  output logic                   clk_div
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       out;
  } cbcs_dv_s;
  cbcs_dv_s st_r;
  cbcs_dv_s st_nxt;
  logic [4:0] lim;

  always_comb begin
    case (ratio)
      cbcs_pkg::CBCS_D1:  lim = 5'h01;
      cbcs_pkg::CBCS_D2:  lim = 5'h02;
      cbcs_pkg::CBCS_D4:  lim = 5'h04;
      cbcs_pkg::CBCS_D5:  lim = 5'h05;
      cbcs_pkg::CBCS_D8:  lim = 5'h08;
      cbcs_pkg::CBCS_D10: lim = 5'h0A;
      cbcs_pkg::CBCS_D16: lim = 5'h10;
      cbcs_pkg::CBCS_D20: lim = 5'h14;
      cbcs_pkg::CBCS_D25: lim = 5'h19;
      default:            lim = 5'h01;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (tick) begin
      if (st_r.cnt + 5'h01 >= lim) begin
        st_nxt.cnt = 5'h00;
        st_nxt.out = ~st_r.out;
      end else begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_div = st_r.out;

  chk_div_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    !tick |=> $stable(clk_div))
    else $error("divider output moved without a source tick");
endmodule : cbcs_clkdiv

// ===== tb/cbcs_far_end.sv
// Purpose: Far-side model giving byte, first-channel and oscillator ticks and the serial bit
// Assumes: Tick periods in ref_clk cycles, scaled down from line rates to keep runs short
// Notes: Ticks are one-cycle pulses; none is held during reset
`timescale 1ns/1ps
module cbcs_far_end #(
  parameter int BYTE_P  = 4,
  parameter int FIRST_P = 8,
  parameter int VCO_P   = 3
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  output logic      byte_tick_second,
  output logic      byte_tick_first,
  output logic      vco_tick,
  output logic      serializer_bit
);
  int cnt;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cnt <= 0;
    else cnt <= cnt + 1;
  end
  // Recovered byte clock, line rate over 20 after scaling
  assign byte_tick_second = resetn && (cnt % BYTE_P) == BYTE_P - 1;
  assign byte_tick_first  = resetn && (cnt % FIRST_P) == FIRST_P - 1;
  assign vco_tick         = resetn && (cnt % VCO_P) == VCO_P - 1;
  // Held high so a zero on the serial output shows blanking
  assign serializer_bit   = 1'b1;
endmodule : cbcs_far_end

// ===== tb/tb_cbcs_top.sv
// Purpose: Self-checking bench for the channel B clock and status block
// Assumes: One wait state per Avalon access, byte ticks every 4 cycles
// Notes: Clock-out rates are judged by toggle counts over a fixed window
`timescale 1ns/1ps
`include "cbcs_map.svh"
module tb_cbcs_top;
  logic        ref_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable, spi, lts, lfd, spo;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [1:0]  avs_response, r;
  logic        ser, tx, pd2_n, pd1_n, pdr1, refpin, ref1, lo, loe, bt2, bt1, vt;
  logic        co, coe, bcf, dpr, irq, co_prev;
  logic [7:0]  mv;
  int          fails, tests_run, co_cnt, bf_cnt, dp_cnt, n;
  int          dv[9] = '{1, 2, 4, 5, 8, 10, 16, 20, 25};

  cbcs_top #(.LANES(4)) DUT (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .slow_parallel_in_second(spi), .lanes_to_serializer(lts), .lanes_from_deserializer(lfd),
    .slow_parallel_out_second(spo), .serializer_bit(ser), .fast_serial_tx_second(tx),
    .fast_serial_rx_second_mvpp(mv), .power_down_pin_second_n(pd2_n),
    .power_down_pin_first_n(pd1_n), .pd_reg_first(pdr1), .ref_select_pin_second(refpin),
    .ref_use_clock_one(ref1), .signal_loss_flag_second_o(lo), .signal_loss_flag_second_oe(loe),
    .byte_tick_second(bt2), .byte_tick_first(bt1), .vco_tick(vt), .clock_output_second_o(co),
    .clock_output_second_oe(coe), .byte_clock_to_first(bcf), .datapath_reset(dpr), .irq(irq));
  cbcs_far_end FAR (.ref_clk(ref_clk), .resetn(resetn), .byte_tick_second(bt2),
    .byte_tick_first(bt1), .vco_tick(vt), .serializer_bit(ser));

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (co !== co_prev) co_cnt++;
    if (bcf === 1'b1) bf_cnt++;
    if (dpr === 1'b1) dp_cnt++;
    co_prev = co;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkr(input string nm, input int lo_b, input int hi_b, input int g);
    tests_run++;
    if (g < lo_b || g > hi_b) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo_b, hi_b, g);
    end
  endtask : chkr
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge ref_clk);
    avs_address   <= ad;
    avs_writedata <= dt;
    avs_write     <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge ref_clk);
    avs_address <= ad;
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    dt = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
  endtask : rd
  task automatic meas(input logic [31:0] w, output int k);
    wr(`CBCS_OFF_CLK, w);
    cyc(20);
    co_cnt = 0;
    cyc(400);
    k = co_cnt;
  endtask : meas
  task automatic end_of_test;
    $display("Counts tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial begin
    #3000000;
    fails++;
    end_of_test();
  end

  initial begin
    resetn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; spi = 4'hF; lfd = 4'hF;
    pd2_n = 1'b1; pd1_n = 1'b1; pdr1 = 1'b0; refpin = 1'b0; mv = 8'hC8; co_prev = 1'b0;
    cyc(5);
    chk("tx in reset", 32'h0, tx);
    chk("lanes in reset", 32'h0, spo);
    chk("clkout in reset", 32'h0, co);
    chk("loss pin in reset", 32'h2, {loe, lo});
    @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`CBCS_OFF_CTRL, d, r);
    chk("ctrl reset", `CBCS_CTRL_RESET, d);
    rd(`CBCS_OFF_CLK, d, r);
    chk("clk reset", `CBCS_CLK_RESET, d);
    chk("ref after reset", 32'h0, ref1);
    $display("Test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(`CBCS_OFF_CTRL, 32'h4 | (i << 8));
      cyc(3);
      chk("tx lanes", (i == 0) ? 32'h1 : (i == 1) ? 32'h3 : 32'hF, lts);
      chk("rx lanes", (i == 0) ? 32'h1 : (i == 1) ? 32'h3 : 32'hF, spo);
    end
    refpin <= 1'b1;
    cyc(3);
    chk("ref pin high", 32'h1, ref1);
    refpin <= 1'b0;
    cyc(3);
    chk("ref pin low", 32'h0, ref1);
    // Pin tied low while software selects
    wr(`CBCS_OFF_CTRL, 32'h16);
    cyc(3);
    chk("ref by bit", 32'h1, ref1);
    chk("observe ref", 32'h1, lo);
    wr(`CBCS_OFF_CTRL, 32'h4);
    cyc(3);
    chk("observe loss", 32'h0, lo);
    $display("Test lanes and reference done");
    wr(`CBCS_OFF_IRQ_STAT, 32'h7);
    mv <= 8'h4B;
    cyc(3);
    chk("loss at 75", 32'h0, lo);
    mv <= 8'h4A;
    cyc(3);
    chk("loss at 74", 32'h1, lo);
    rd(`CBCS_OFF_IRQ_STAT, d, r);
    chk("irq status set", 32'h1, d);
    rd(`CBCS_OFF_STATUS, d, r);
    chk("status loss", 32'h1, d);
    rd(`CBCS_OFF_LEVEL, d, r);
    chk("swing level", 32'h4A, d);
    wr(`CBCS_OFF_IRQ_MASK, 32'h0);
    cyc(2);
    chk("irq masked", 32'h0, irq);
    wr(`CBCS_OFF_IRQ_MASK, 32'h7);
    cyc(2);
    chk("irq unmasked", 32'h1, irq);
    wr(`CBCS_OFF_IRQ_STAT, 32'h1);
    rd(`CBCS_OFF_IRQ_STAT, d, r);
    chk("irq status clear", 32'h0, d);
    chk("irq low", 32'h0, irq);
    mv <= 8'h96;
    cyc(3);
    chk("loss at 150", 32'h1, lo);
    mv <= 8'h97;
    cyc(3);
    chk("loss at 151", 32'h0, lo);
    rd(`CBCS_OFF_IRQ_STAT, d, r);
    chk("irq loss clear", 32'h2, d);
    $display("Test loss flag done");
    pd2_n <= 1'b0;
    cyc(3);
    chk("pin down outputs", 32'h0, {loe, tx, lts});
    chk("clkout one down", 32'h1, coe);
    pd1_n <= 1'b0;
    cyc(3);
    chk("clkout both down", 32'h0, coe);
    pd2_n <= 1'b1;
    pd1_n <= 1'b1;
    cyc(3);
    chk("pin up loss oe", 32'h1, loe);
    chk("pin up tx", 32'h1, tx);
    dp_cnt = 0;
    wr(`CBCS_OFF_CTRL, 32'hC);
    cyc(3);
    chk("datapath reset", 32'h1, dp_cnt);
    pdr1 <= 1'b1;
    wr(`CBCS_OFF_CTRL, 32'h8004);
    cyc(3);
    chk("reg down pins", 32'h0, {loe, coe});
    wr(`CBCS_OFF_CTRL, 32'h4);
    pdr1 <= 1'b0;
    $display("Test power down done");
    for (int i = 0; i < 9; i++) begin
      meas((i << 4) | 1, n);
      chkr("byte divider", 100 / dv[i] - 1, 100 / dv[i] + 1, n);
    end
    meas(32'h3, n);
    chkr("vco source", 132, 135, n);
    meas(32'h5, n);
    chkr("first source", 49, 51, n);
    meas(32'h0, n);
    chk("clkout disabled", 32'h0, n);
    wr(`CBCS_OFF_CLK, 32'h101);
    bf_cnt = 0;
    cyc(100);
    chkr("steer to first", 24, 26, bf_cnt);
    rd(4'hF, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", 32'h2, r);
    $display("Test clock out done");
    end_of_test();
  end
endmodule : tb_cbcs_top
